// ==== include/acq_result_a_consts.vh ====
/*
  Constants for the acquisition diagnostic control block: diagnostic select
  codes, switch diagnostic mode codes, forced configuration values, expected
  self-test readings and the sense-wire settling time.
  Assumes a 20 MHz system clock and 16-bit converter words.
*/
`ifndef ACQ_RESULT_A_CONSTS_VH
`define ACQ_RESULT_A_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
`define DSEL_OFF 3'h0
`define DSEL_ALTERNATE_REFERENCE 3'h1
`define DSEL_SUPPLY 3'h2
`define DSEL_OFFSET 3'h3
`define DSEL_ZERO 3'h4
`define DSEL_FULL 3'h5

`define SWD_OFF 3'h0
`define SWD_SHORT 3'h1
`define SWD_OPEN 3'h2
`define SWD_ODD 3'h5
`define SWD_EVEN 3'h6

////////////////////////////////////////////////////////////////////////////////
`define MEAS_AUX_LSB 12
`define RESULT_LSB 2
`define MEAS_AUX_OFF 3'h0
`define SWITCHES_OFF 12'h000
`define ODD_SWITCHES 12'h555
`define EVEN_SWITCHES 12'hAAA
`define LAST_CELL 4'hB
`define LAST_CHANNEL 4'hE
`define RESULT_A_CHANNEL 4'hF

`define ALTERNATE_REFERENCE_MIN 16'h3EF8
`define ALTERNATE_REFERENCE_MAX 16'h4034
`define ZERO_SCALE 16'h0000
`define FULL_SCALE 16'hFFF0
`define SHORT_MARGIN_MV 100

////////////////////////////////////////////////////////////////////////////////
`define CLK_MHZ 20
`define SETTLE_US 100
`define SETTLE_CYCLES (`SETTLE_US * `CLK_MHZ)

`endif

// ==== rtl/acq_result_a_control.v ====
/*
  Acquisition sequencer with diagnostic slot and balancing-switch diagnostic
  modes: overrides the host configuration, runs the scan, compares results
  and keeps sticky alert flags.
  Assumes the converter sits on clk_sys, takes a one-cycle conv_start and
  answers with a one-cycle conv_done carrying conv_data.
*/
`timescale 1ns/1ps
`include "acq_result_a_consts.vh"

module acq_result_a_control #(
  parameter W = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire acq_start,
  input wire [2:0] result_a_select,
  input wire [2:0] switch_result_a_mode,
  input wire [14:0] measure_enable_cfg,
  input wire [11:0] balance_switch_enable_cfg,
  input wire alt_path_select_cfg,
  input wire polarity_cfg,
  input wire chop_cfg,
  input wire [W-1:0] short_threshold,
  input wire [W-1:0] low_threshold,
  input wire [W-1:0] high_threshold,
  input wire [W-1:0] ov_threshold,
  input wire [W-1:0] uv_threshold,
  input wire [W-1:0] mismatch_threshold,
  input wire [11:0] switch_alert_clear,
  input wire [11:0] ov_clear,
  input wire [11:0] uv_clear,
  input wire mismatch_clear,
  input wire conv_done,
  input wire [W-1:0] conv_data,
  output reg [14:0] measure_enable_q,
  output reg [11:0] balance_switch_enable_q,
  output reg alt_path_select_q,
  output reg polarity_bipolar_q,
  output reg chop_enable_q,
  output reg thermistor_bias_ref_q,
  output reg [2:0] result_a_source_q,
  output reg conv_start_q,
  output reg [3:0] conv_channel_q,
  output reg [W-1:0] result_a_q,
  output reg [11:0] switch_result_a_alert_flags_q,
  output reg [11:0] overvoltage_alert_q,
  output reg [11:0] undervoltage_alert_q,
  output reg mismatch_alert_q,
  output reg acq_busy_q,
  output reg acq_done_q,
  output reg settle_done_q
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SCAN = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_RESULT_A_SETUP = 3'h3;
  localparam [2:0] S_RESULT_A_REQ = 3'h4;
  localparam [2:0] S_RESULT_A_WAIT = 3'h5;
  localparam [2:0] S_FINISH = 3'h6;
  localparam [31:0] SETTLE_FULL = `SETTLE_CYCLES;
  localparam [11:0] SETTLE_CYC = SETTLE_FULL[11:0];

  ////////////////////////////////////////////////////////////////////////////
  function mode_active;
    input [2:0] m;
    begin
      mode_active = (m == `SWD_SHORT) || (m == `SWD_OPEN) ||
        (m == `SWD_ODD) || (m == `SWD_EVEN);
    end
  endfunction

  function sense_mode;
    input [2:0] m;
    begin
      sense_mode = (m == `SWD_ODD) || (m == `SWD_EVEN);
    end
  endfunction

  function result_a_valid;
    input [2:0] s;
    begin
      result_a_valid = (s >= `DSEL_ALTERNATE_REFERENCE) && (s <= `DSEL_FULL);
    end
  endfunction

  function [11:0] cell_bit;
    input [3:0] idx;
    begin
      cell_bit = 12'h001 << idx;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg [2:0] state_q;
  reg [3:0] ch_q;
  reg result_a_bipolar_q;
  reg result_a_nochop_q;
  reg result_a_thrm_q;
  reg [W-1:0] max_q;
  reg [W-1:0] min_q;
  reg seen_q;
  reg mismatch_set_q;
  reg [2:0] mode_prev_q;
  reg [11:0] settle_cnt_q;

  reg [14:0] meas_d;
  reg [11:0] bal_d;
  reg alt_d;
  reg pol_d;

  wire suppress;
  wire switch_fault;
  wire ov_hit;
  wire uv_hit;
  wire cell_take;
  wire [11:0] hit_bit;
  wire [11:0] sw_set;
  wire [11:0] ov_set;
  wire [11:0] uv_set;

  assign suppress = mode_active(switch_result_a_mode);
  assign cell_take = (state_q == S_WAIT) && conv_done && (ch_q <= `LAST_CELL);
  assign hit_bit = cell_take ? cell_bit(ch_q) : 12'h000;
  assign sw_set = switch_fault ? hit_bit : 12'h000;
  assign ov_set = ov_hit ? hit_bit : 12'h000;
  assign uv_set = uv_hit ? hit_bit : 12'h000;

  cell_compare #(
    .W(W)
  ) u_compare (
    .mode(switch_result_a_mode),
    .suppress(suppress),
    .cell_en(|(balance_switch_enable_cfg & cell_bit(ch_q))),
    .data(conv_data),
    .short_threshold(short_threshold),
    .low_threshold(low_threshold),
    .high_threshold(high_threshold),
    .ov_threshold(ov_threshold),
    .uv_threshold(uv_threshold),
    .switch_fault(switch_fault),
    .ov_hit(ov_hit),
    .uv_hit(uv_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // overrides are a mux over the host copy, so leaving a mode restores it
  always @* begin
    meas_d = measure_enable_cfg;
    bal_d = balance_switch_enable_cfg;
    alt_d = alt_path_select_cfg;
    pol_d = polarity_cfg;
    case (switch_result_a_mode)
      `SWD_SHORT: begin
        meas_d[14:12] = `MEAS_AUX_OFF;
        bal_d = `SWITCHES_OFF;
        alt_d = 1'b1;
      end
      `SWD_OPEN: begin
        meas_d = {`MEAS_AUX_OFF, balance_switch_enable_cfg};
        alt_d = 1'b1;
        pol_d = 1'b1;
      end
      `SWD_ODD: begin
        bal_d = `ODD_SWITCHES;
        alt_d = 1'b1;
      end
      `SWD_EVEN: begin
        bal_d = `EVEN_SWITCHES;
        alt_d = 1'b1;
      end
      default: begin
        meas_d = measure_enable_cfg;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      measure_enable_q <= 15'h0000;
      balance_switch_enable_q <= 12'h000;
      alt_path_select_q <= 1'b0;
      polarity_bipolar_q <= 1'b0;
      chop_enable_q <= 1'b0;
      thermistor_bias_ref_q <= 1'b0;
    end else begin
      measure_enable_q <= meas_d;
      balance_switch_enable_q <= bal_d;
      alt_path_select_q <= alt_d;
      polarity_bipolar_q <= pol_d | result_a_bipolar_q;
      chop_enable_q <= chop_cfg & ~result_a_nochop_q;
      thermistor_bias_ref_q <= result_a_thrm_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: cells and aux channels in order, then the diagnostic slot
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q <= S_IDLE;
      ch_q <= 4'h0;
      conv_start_q <= 1'b0;
      conv_channel_q <= 4'h0;
      result_a_source_q <= `DSEL_OFF;
      result_a_bipolar_q <= 1'b0;
      result_a_nochop_q <= 1'b0;
      result_a_thrm_q <= 1'b0;
      result_a_q <= 16'h0000;
      acq_busy_q <= 1'b0;
      acq_done_q <= 1'b0;
      max_q <= 16'h0000;
      min_q <= 16'hFFFF;
      seen_q <= 1'b0;
      mismatch_set_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      acq_done_q <= 1'b0;
      mismatch_set_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          // a start while busy is dropped, host must wait for acq_done
          if (acq_start) begin
            ch_q <= 4'h0;
            acq_busy_q <= 1'b1;
            max_q <= 16'h0000;
            min_q <= 16'hFFFF;
            seen_q <= 1'b0;
            state_q <= S_SCAN;
          end
        end
        S_SCAN: begin
          if (ch_q > `LAST_CHANNEL) begin
            state_q <= result_a_valid(result_a_select) ? S_RESULT_A_SETUP : S_FINISH;
          end else if (measure_enable_q[ch_q]) begin
            conv_start_q <= 1'b1;
            conv_channel_q <= ch_q;
            state_q <= S_WAIT;
          end else begin
            ch_q <= ch_q + 4'h1;
          end
        end
        S_WAIT: begin
          if (conv_done) begin
            if (ch_q <= `LAST_CELL && !suppress) begin
              seen_q <= 1'b1;
              if (conv_data > max_q) begin
                max_q <= conv_data;
              end
              if (conv_data < min_q) begin
                min_q <= conv_data;
              end
            end
            ch_q <= ch_q + 4'h1;
            state_q <= S_SCAN;
          end
        end
        S_RESULT_A_SETUP: begin
          result_a_source_q <= result_a_select;
          result_a_bipolar_q <= (result_a_select == `DSEL_OFFSET) ||
            (result_a_select == `DSEL_ZERO) || (result_a_select == `DSEL_FULL);
          result_a_nochop_q <= result_a_select == `DSEL_OFFSET;
          result_a_thrm_q <= result_a_select == `DSEL_SUPPLY;
          state_q <= S_RESULT_A_REQ;
        end
        S_RESULT_A_REQ: begin
          conv_start_q <= 1'b1;
          conv_channel_q <= `RESULT_A_CHANNEL;
          state_q <= S_RESULT_A_WAIT;
        end
        S_RESULT_A_WAIT: begin
          if (conv_done) begin
            // low bits dropped so a 14-bit code lands in 15:2
            result_a_q <= {conv_data[W-1:`RESULT_LSB], 2'b00};
            state_q <= S_FINISH;
          end
        end
        S_FINISH: begin
          result_a_source_q <= `DSEL_OFF;
          result_a_bipolar_q <= 1'b0;
          result_a_nochop_q <= 1'b0;
          result_a_thrm_q <= 1'b0;
          mismatch_set_q <= seen_q && !suppress &&
            ((max_q - min_q) > mismatch_threshold);
          acq_busy_q <= 1'b0;
          acq_done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags; a set in the clear cycle survives
  always @(posedge clk_sys) begin
    if (rst) begin
      switch_result_a_alert_flags_q <= 12'h000;
      overvoltage_alert_q <= 12'h000;
      undervoltage_alert_q <= 12'h000;
      mismatch_alert_q <= 1'b0;
    end else begin
      switch_result_a_alert_flags_q <= (switch_result_a_alert_flags_q & ~switch_alert_clear) |
        sw_set;
      overvoltage_alert_q <= (overvoltage_alert_q & ~ov_clear) | ov_set;
      undervoltage_alert_q <= (undervoltage_alert_q & ~uv_clear) | uv_set;
      mismatch_alert_q <= (mismatch_alert_q & ~mismatch_clear) | mismatch_set_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settle timer only informs the host; starting early is not blocked
  always @(posedge clk_sys) begin
    if (rst) begin
      mode_prev_q <= `SWD_OFF;
      settle_cnt_q <= 12'h000;
      settle_done_q <= 1'b0;
    end else begin
      mode_prev_q <= switch_result_a_mode;
      if (!sense_mode(switch_result_a_mode) || switch_result_a_mode != mode_prev_q) begin
        settle_cnt_q <= 12'h000;
        settle_done_q <= 1'b0;
      end else if (settle_cnt_q == SETTLE_CYC) begin
        settle_done_q <= 1'b1;
      end else begin
        settle_cnt_q <= settle_cnt_q + 12'h001;
      end
    end
  end

endmodule // acq_result_a_control

// ==== rtl/cell_compare.v ====
/*
  Threshold comparison of one converted cell or switch reading for the
  active switch diagnostic mode, plus the normal over/undervoltage tests.
  Assumes unsigned 16-bit readings and thresholds on the same scale.
*/
`timescale 1ns/1ps
`include "acq_result_a_consts.vh"

module cell_compare #(
  parameter W = 16
) (
  input wire [2:0] mode,
  input wire suppress,
  input wire cell_en,
  input wire [W-1:0] data,
  input wire [W-1:0] short_threshold,
  input wire [W-1:0] low_threshold,
  input wire [W-1:0] high_threshold,
  input wire [W-1:0] ov_threshold,
  input wire [W-1:0] uv_threshold,
  output reg switch_fault,
  output reg ov_hit,
  output reg uv_hit
);

  wire outside;

  assign outside = (data > high_threshold) || (data < low_threshold);

  always @* begin
    switch_fault = 1'b0;
    case (mode)
      `SWD_SHORT: switch_fault = data < short_threshold;
      `SWD_OPEN: switch_fault = cell_en && outside;
      `SWD_ODD: switch_fault = outside;
      `SWD_EVEN: switch_fault = outside;
      default: switch_fault = 1'b0;
    endcase
    ov_hit = !suppress && (data > ov_threshold);
    uv_hit = !suppress && (data < uv_threshold);
  end

endmodule // cell_compare

// ==== test/acq_result_a_asserts.sv ====
/* checker for the acquisition diagnostic control ports
   assumes one clock domain, clk_sys, and synchronous active-high rst */
`timescale 1ns/1ps
`include "acq_result_a_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module acq_result_a_asserts #(
  parameter W = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire acq_start,
  input wire conv_done,
  input wire conv_start_q,
  input wire alt_path_select_q,
  input wire polarity_bipolar_q,
  input wire chop_enable_q,
  input wire thermistor_bias_ref_q,
  input wire acq_busy_q,
  input wire acq_done_q,
  input wire alt_path_select_cfg,
  input wire polarity_cfg,
  input wire [2:0] switch_result_a_mode,
  input wire [2:0] result_a_source_q,
  input wire [3:0] conv_channel_q,
  input wire [11:0] balance_switch_enable_cfg,
  input wire [11:0] balance_switch_enable_q,
  input wire [11:0] switch_alert_clear,
  input wire [11:0] ov_clear,
  input wire [11:0] uv_clear,
  input wire [11:0] switch_result_a_alert_flags_q,
  input wire [11:0] overvoltage_alert_q,
  input wire [11:0] undervoltage_alert_q,
  input wire [14:0] measure_enable_cfg,
  input wire [14:0] measure_enable_q,
  input wire [W-1:0] conv_data,
  input wire [W-1:0] result_a_q
);
  wire sw_on = switch_result_a_mode == `SWD_SHORT || switch_result_a_mode == `SWD_OPEN
    || switch_result_a_mode == `SWD_ODD || switch_result_a_mode == `SWD_EVEN;
  wire result_a_go = conv_start_q && conv_channel_q == `RESULT_A_CHANNEL;
  wire [11:0] flags = switch_result_a_alert_flags_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
////////////////////////////////////////////////////////////////////////////////
  property p_short_cfg;
    switch_result_a_mode == `SWD_SHORT |=> balance_switch_enable_q == `SWITCHES_OFF
      && measure_enable_q[14:12] == `MEAS_AUX_OFF && alt_path_select_q;
  endproperty
  a_short_cfg: assert property (p_short_cfg) else $error("short config wrong");
  property p_open_cfg;
    switch_result_a_mode == `SWD_OPEN |=> polarity_bipolar_q && alt_path_select_q
      && measure_enable_q == {3'b000, $past(balance_switch_enable_cfg)};
  endproperty
  a_open_cfg: assert property (p_open_cfg) else $error("open config wrong");
  property p_restore;
    switch_result_a_mode == `SWD_OFF && !acq_busy_q |=> measure_enable_q == $past(measure_enable_cfg)
      && balance_switch_enable_q == $past(balance_switch_enable_cfg)
      && alt_path_select_q == $past(alt_path_select_cfg) && polarity_bipolar_q == $past(polarity_cfg);
  endproperty
  a_restore: assert property (p_restore) else $error("host config not restored");
  property p_sense;
    switch_result_a_mode == `SWD_ODD || switch_result_a_mode == `SWD_EVEN |=> alt_path_select_q
      && balance_switch_enable_q == ($past(switch_result_a_mode) == `SWD_ODD ? `ODD_SWITCHES
      : `EVEN_SWITCHES);
  endproperty
  a_sense: assert property (p_sense) else $error("sense mode switches wrong");
  property p_suppress;
    sw_on && conv_done && ov_clear == 12'h000 && uv_clear == 12'h000 |=>
      $stable(overvoltage_alert_q) && $stable(undervoltage_alert_q);
  endproperty
  a_suppress: assert property (p_suppress) else $error("voltage alert in switch mode");
  property p_offset;
    result_a_go && result_a_source_q == `DSEL_OFFSET |-> polarity_bipolar_q && !chop_enable_q;
  endproperty
  a_offset: assert property (p_offset) else $error("offset not bipolar unchopped");
  property p_bipolar;
    result_a_go && (result_a_source_q == `DSEL_ZERO || result_a_source_q == `DSEL_FULL) |-> polarity_bipolar_q;
  endproperty
  a_bipolar: assert property (p_bipolar) else $error("scale test not bipolar");
  property p_thermref;
    result_a_go && result_a_source_q == `DSEL_SUPPLY |-> thermistor_bias_ref_q;
  endproperty
  a_thermref: assert property (p_thermref) else $error("supply test reference wrong");
  property p_result;
    conv_done && acq_busy_q && result_a_source_q != `DSEL_OFF |=> result_a_q[1:0] == 2'b00
      && (result_a_q >> `RESULT_LSB) == ($past(conv_data) >> `RESULT_LSB);
  endproperty
  a_result: assert property (p_result) else $error("result not stored");
  property p_sticky;
    switch_alert_clear == 12'h000 |=> (flags & $past(flags)) == $past(flags);
  endproperty
  a_sticky: assert property (p_sticky) else $error("alert flag dropped");
  property p_start;
    acq_start && !acq_busy_q && !acq_done_q |=> acq_busy_q;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  c_done: cover property (acq_done_q);
  c_offset: cover property (result_a_go && result_a_source_q == `DSEL_OFFSET);
  c_flag: cover property (flags != 12'h000);
endmodule // acq_result_a_asserts

bind acq_result_a_control acq_result_a_asserts #(.W(W)) acq_result_a_asserts_inst (.*);

// ==== test/conv_model.sv ====
/* converter stand-in answering each conversion request with one conv_done
   pulse; assumes one request outstanding and channel valid with the request */
`timescale 1ns/1ps
`include "acq_result_a_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module conv_model (
  input wire clk_sys,
  input wire rst,
  input wire conv_start,
  input wire slow,
  input wire [3:0] ch,
  input wire [3:0] low_ch,
  input wire [2:0] src,
  output reg conv_done = 1'b0,
  output reg [15:0] conv_data = 16'h0000
);
  localparam [15:0] CELL_V = 16'h8000;
  localparam [15:0] LOW_V = 16'h0100;
  reg [2:0] wait_q = 3'h0;
  reg [15:0] val_q = 16'h0000;
  always @(posedge clk_sys) begin
    conv_done <= 1'b0;
    // never leave a stale word on the bus between answers
    conv_data <= ~conv_data;
    if (rst) begin
      wait_q <= 3'h0;
    end else if (conv_start) begin
      wait_q <= slow ? 3'h4 : 3'h1;
      if (ch != `RESULT_A_CHANNEL) val_q <= (ch == low_ch) ? LOW_V : CELL_V;
      else if (src == `DSEL_ALTERNATE_REFERENCE) val_q <= 16'h4002;
      else if (src == `DSEL_ZERO) val_q <= `ZERO_SCALE;
      else if (src == `DSEL_FULL) val_q <= 16'hFFF3;
      else val_q <= 16'h1237;
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
      if (wait_q == 3'h1) begin
        conv_done <= 1'b1;
        conv_data <= val_q;
      end
    end
  end
endmodule // conv_model

// ==== test/tb_acq_result_a_control.sv ====
/* self-checking bench for acq_result_a_control with conv_model on the far side
   assumes a 20 MHz clk_sys and the constants of acq_result_a_consts.vh */
`timescale 1ns/1ps
`include "acq_result_a_consts.vh"
`define CHK(n, e, g) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
  bad_count = bad_count + 1; $display("FAIL %s exp %h got %h", n, e, g); end end
////////////////////////////////////////////////////////////////////////////////
module tb_acq_result_a_control;
  reg clk_sys = 1'b0, rst = 1'b1, acq_start = 1'b0, slow = 1'b0, mismatch_clear = 1'b0;
  reg alt_path_select_cfg = 1'b0, polarity_cfg = 1'b0, chop_cfg = 1'b1;
  reg [2:0] result_a_select = 3'h0, switch_result_a_mode = 3'h0;
  reg [3:0] low_ch = 4'hF;
  reg [11:0] balance_switch_enable_cfg = 12'h0F0, switch_alert_clear = 12'h000;
  reg [11:0] ovuv_clr = 12'h000;
  reg [14:0] measure_enable_cfg = 15'h7FFF;
  reg [15:0] short_threshold = 16'h7000;
  reg [15:0] low_threshold = 16'h0200, high_threshold = 16'h9000, ov_threshold = 16'h7800;
  reg [15:0] uv_threshold = 16'h0000, mismatch_threshold = 16'hFFFF;
  wire conv_done, conv_start_q, alt_path_select_q, polarity_bipolar_q, chop_enable_q;
  wire thermistor_bias_ref_q, mismatch_alert_q, acq_busy_q, acq_done_q, settle_done_q;
  wire [2:0] result_a_source_q;
  wire [3:0] conv_channel_q;
  wire [11:0] balance_switch_enable_q, switch_result_a_alert_flags_q;
  wire [11:0] overvoltage_alert_q, undervoltage_alert_q;
  wire [14:0] measure_enable_q;
  wire [15:0] conv_data, result_a_q;
  wire ref_ok = result_a_q >= `ALTERNATE_REFERENCE_MIN && result_a_q <= `ALTERNATE_REFERENCE_MAX;
  integer bad_count = 0, cmp_count = 0, cyc = 0, i, n;
  acq_result_a_control acq_result_a_control_inst (.ov_clear(ovuv_clr), .uv_clear(ovuv_clr), .*);
  conv_model conv_model_inst (.clk_sys(clk_sys), .rst(rst), .conv_start(conv_start_q),
    .slow(slow), .ch(conv_channel_q), .low_ch(low_ch), .src(result_a_source_q),
    .conv_done(conv_done), .conv_data(conv_data));
////////////////////////////////////////////////////////////////////////////////
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      close_out;
    end
  end
  function [15:0] exp_result_a(input [2:0] s);
    case (s)
      `DSEL_ALTERNATE_REFERENCE: exp_result_a = 16'h4000;
      `DSEL_ZERO: exp_result_a = `ZERO_SCALE;
      `DSEL_FULL: exp_result_a = `FULL_SCALE;
      default: exp_result_a = 16'h1234;
    endcase
  endfunction
  task tick(input integer k);
    repeat (k) @(posedge clk_sys);
  endtask
  task run_acq;
    begin
      acq_start <= 1'b1;
      tick(1);
      acq_start <= 1'b0;
      n = 0;
      while (acq_done_q !== 1'b1 && n < 500) begin
        tick(1);
        n = n + 1;
      end
      `CHK("acq_done", 1'b1, acq_done_q)
      tick(1);
    end
  endtask
  task clr_flags;
    begin
      switch_alert_clear <= 12'hFFF;
      ovuv_clr <= 12'hFFF;
      mismatch_clear <= 1'b1;
      tick(1);
      switch_alert_clear <= 12'h000;
      ovuv_clr <= 12'h000;
      mismatch_clear <= 1'b0;
      tick(1);
    end
  endtask
  task close_out;
    begin
      if (bad_count == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(16);
    rst <= 1'b0;
    tick(2);
    `CHK("flags_rst", 12'h000, switch_result_a_alert_flags_q)
    for (i = 1; i < 6; i = i + 1) begin
      result_a_select <= i[2:0];
      slow <= i[0];
      run_acq;
      `CHK("result_a", exp_result_a(i[2:0]), result_a_q)
      if (i == 1) `CHK("ref_rng", 1'b1, ref_ok)
    end
    result_a_select <= `DSEL_OFF;
    `CHK("ov_off", 12'hFFF, overvoltage_alert_q)
    clr_flags;
    `CHK("ov_clr", 12'h000, overvoltage_alert_q)
    switch_result_a_mode <= `SWD_SHORT;
    low_ch <= 4'h3;
    tick(2);
    `CHK("short_sw", `SWITCHES_OFF, balance_switch_enable_q)
    `CHK("short_aux", `MEAS_AUX_OFF, measure_enable_q[14:12])
    `CHK("short_alt", 1'b1, alt_path_select_q)
    run_acq;
    `CHK("short_flags", 12'h008, switch_result_a_alert_flags_q)
    `CHK("short_ov", 12'h000, overvoltage_alert_q)
    low_ch <= 4'hF;
    run_acq;
    `CHK("sticky", 12'h008, switch_result_a_alert_flags_q)
    clr_flags;
    `CHK("cleared", 12'h000, switch_result_a_alert_flags_q)
    switch_result_a_mode <= `SWD_OPEN;
    low_ch <= 4'h5;
    tick(2);
    `CHK("open_meas", {3'b000, 12'h0F0}, measure_enable_q)
    `CHK("open_pol", 1'b1, polarity_bipolar_q)
    run_acq;
    `CHK("open_flags", 12'h020, switch_result_a_alert_flags_q)
    switch_result_a_mode <= `SWD_OFF;
    tick(2);
    `CHK("rest_meas", 15'h7FFF, measure_enable_q)
    `CHK("rest_sw", 12'h0F0, balance_switch_enable_q)
    `CHK("rest_alt", 1'b0, alt_path_select_q)
    `CHK("rest_pol", 1'b0, polarity_bipolar_q)
    clr_flags;
    for (i = 0; i < 2; i = i + 1) begin
      switch_result_a_mode <= i ? `SWD_EVEN : `SWD_ODD;
      low_ch <= i ? 4'h6 : 4'h1;
      n = 0;
      while (settle_done_q !== 1'b1 && n < 3000) begin
        tick(1);
        n = n + 1;
      end
      `CHK("settle_n", 1'b1, n >= `SETTLE_CYCLES && n <= `SETTLE_CYCLES + 4)
      `CHK("sense_sw", i ? `EVEN_SWITCHES : `ODD_SWITCHES, balance_switch_enable_q)
      run_acq;
      `CHK("sense_flags", i ? 12'h040 : 12'h002, switch_result_a_alert_flags_q)
      switch_result_a_mode <= `SWD_OFF;
      clr_flags;
    end
    // normal mode trips undervoltage and mismatch, a switch mode must not
    uv_threshold <= 16'h0200;
    mismatch_threshold <= 16'h1000;
    low_ch <= 4'h2;
    run_acq;
    `CHK("uv_flags", 12'h004, undervoltage_alert_q)
    `CHK("mismatch", 1'b1, mismatch_alert_q)
    clr_flags;
    `CHK("mm_clr", 1'b0, mismatch_alert_q)
    switch_result_a_mode <= `SWD_SHORT;
    run_acq;
    `CHK("short_low", 12'h004, switch_result_a_alert_flags_q)
    `CHK("sw_uv", 12'h000, undervoltage_alert_q)
    `CHK("sw_mismatch", 1'b0, mismatch_alert_q)
    close_out;
  end
endmodule // tb_acq_result_a_control
